// file: dv/dac_ctrl_tb_top.sv
/*
 * dac_ctrl_tb_top: self-checking bench for dac_ctrl with a serial host.
 * assumes a 20 MHz system clock and a free 400 ns converter input clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_tb_top;
    import dac_pkg::*;
    typedef struct packed {
        logic [4:0] ga;
        logic [4:0] gb;
        logic sg;
        logic ck;
        logic bs;
    } dac_row_s;
    logic sys_clk = 1'b0, rst_n = 1'b0, conv_clk = 1'b0, refpd = 1'b0, standby_in = 1'b0;
    logic go = 1'b0, sclk, cs_n, serial_config_data_in, busy;
    logic [15:0] word = 16'h0000;
    logic [4:0] nbits = 5'h10;
    logic [9:0] core_a = 10'h000, core_b = 10'h000, bus_a, bus_b, ea, eb;
    logic ref_en, powered, isc, sgn, bcnt, ckopt, cerr, b_en, dvalid;
    logic [4:0] gain_a, gain_b;
    logic [15:0] e16;
    int fail_count = 0, n_tests = 0, rises = 0, k;
    dac_row_s rows [4] = '{'{5'h01, 5'h1f, 1'b0, 1'b0, 1'b0}, '{5'h1f, 5'h00, 1'b1, 1'b1, 1'b0},
                           '{5'h0a, 5'h15, 1'b0, 1'b0, 1'b1}, '{5'h10, 5'h03, 1'b1, 1'b1, 1'b1}};
    // clocks: system 50 ns, converter input 400 ns with an unrelated phase
    always #25 sys_clk = ~sys_clk;
    initial begin
        #37;
        forever #200 conv_clk = ~conv_clk;
    end
    always @(posedge conv_clk) rises <= rises + 1;
    dac_host host (.go_i(go), .word_i(word), .nbits_i(nbits), .sclk_o(sclk), .cs_n_o(cs_n),
                   .sdi_o(serial_config_data_in), .busy_o(busy));
    dac_ctrl dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .conv_clk_i(conv_clk),
                  .reference_powerdown_in_i(refpd), .standby_in_i(standby_in), .sclk_i(sclk),
                  .cs_n_i(cs_n), .serial_config_data_in_i(serial_config_data_in), .core_a_i(core_a),
                  .core_b_i(core_b), .ref_enable_o(ref_en), .core_powered_o(powered),
                  .gain_a_o(gain_a), .gain_b_o(gain_b), .internal_sample_clock_o(isc),
                  .signed_output_select_o(sgn), .bus_count_option_o(bcnt),
                  .clk_option_o(ckopt), .cfg_error_o(cerr), .bus_a_o(bus_a), .bus_b_o(bus_b),
                  .bus_b_en_o(b_en), .data_valid_o(dvalid));
    // compare any value, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic results();
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one serial write through the host, waits for its end under a bound
    task automatic wr(input logic [15:0] w, input logic [4:0] n);
        @(posedge sys_clk);
        word <= w;
        nbits <= n;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
        @(posedge sys_clk);
    endtask
    // hang guard
    initial begin
        #200000;
        fail_count++;
        results();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({8'h00, ref_en, powered, isc, b_en, cerr, sgn, ckopt, bcnt}, 16'h00f0);
        chk({6'h00, gain_a, gain_b}, 16'h0000);
        $display("test reset done");
        for (k = 0; k < 4; k++) begin
            wr({3'h0, rows[k].bs, rows[k].ck, rows[k].sg, rows[k].gb, rows[k].ga}, 5'h10);
            e16 = {12'h000, rows[k].sg, rows[k].ck, rows[k].bs, ~rows[k].bs};
            chk({12'h000, sgn, ckopt, bcnt, b_en}, e16);
            repeat (40) @(posedge sys_clk);
            chk({6'h00, gain_a, gain_b}, {6'h00, rows[k].ga, rows[k].gb});
        end
        $display("test config table done");
        wr(16'h0000, 5'h08);
        chk({12'h000, cerr, sgn, ckopt, bcnt}, 16'h000f);
        repeat (40) @(posedge sys_clk);
        chk({6'h00, gain_a, gain_b}, {6'h00, 5'h10, 5'h03});
        $display("test short write done");
        standby_in <= 1'b1;
        refpd <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({12'h000, powered, dvalid, b_en, ref_en}, 16'h0000);
        standby_in <= 1'b0;
        refpd <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({14'h0000, powered, ref_en}, 16'h0003);
        $display("test power pins done");
        wr({3'h0, 1'b0, 1'b1, 1'b1, 5'h02, 5'h04}, 5'h10);
        chk({15'h0000, cerr}, 16'h0000);
        core_a <= 10'h155;
        core_b <= 10'h0aa;
        repeat (40) @(posedge conv_clk);
        chk({15'h0000, dvalid}, 16'h0001);
        @(negedge conv_clk);
        @(posedge sys_clk);
        core_a <= 10'h2c3;
        core_b <= 10'h03c;
        rises <= 0;
        ea = 10'h2c3 ^ SMP_SIGN;
        eb = 10'h03c ^ SMP_SIGN;
        for (int i = 0; i < 400 && bus_a !== ea; i++) @(posedge sys_clk);
        chk(16'(rises), 16'(LAT_DUAL_40 + 1));
        chk({bus_a, 6'h00}, {ea, 6'h00});
        chk({bus_b, 6'h00}, {eb, 6'h00});
        $display("test latency done");
        // single bus at 80 MHz input, unsigned: bus b trails bus a by one input rise
        wr(16'h1000, 5'h10);
        core_a <= 10'h0f0;
        core_b <= 10'h30f;
        for (int i = 0; i < 400 && bus_a !== 10'h0f0; i++) @(posedge sys_clk);
        rises <= 0;
        for (int i = 0; i < 400 && bus_b !== 10'h30f; i++) @(posedge sys_clk);
        chk(16'(rises), 16'(LAT_SGL_B - LAT_SGL_A));
        chk({14'h0000, b_en, bcnt}, 16'h0001);
        $display("test single bus done");
        results();
    end
endmodule // dac_ctrl_tb_top
`default_nettype wire

// file: dv/dac_host.sv
/*
 * dac_host: behavioural host controller that writes configuration words
 * over the three-wire serial port.
 * assumes go_i is pulsed for one system clock while busy_o is low.
 */
`timescale 1ns/1ps
`default_nettype none
module dac_host (
    // command
    input wire logic go_i,
    input wire logic [15:0] word_i,
    input wire logic [4:0] nbits_i,
    // serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    // status
    output logic busy_o
);
    localparam int HALF_NS = 150; // slower than 20 MHz, 25 ns minimum met
    int i;
    // idle: clock parked high, select released
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        busy_o = 1'b0;
    end
    // one write, msb first; data stable well around each falling edge
    always @(posedge go_i) begin
        busy_o = 1'b1;
        cs_n_o = 1'b0;
        for (i = 0; i < nbits_i; i++) begin
            sdi_o = word_i[15 - i];
            #(HALF_NS);
            sclk_o = 1'b0;
            #(HALF_NS);
            sclk_o = 1'b1;
        end
        #(HALF_NS);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line shows no stale value
        #(2 * HALF_NS);
        busy_o = 1'b0;
    end
endmodule // dac_host
`default_nettype wire

// file: verilog/dac_ctrl.sv
/*
 * dac_ctrl: digital control of a dual pipelined converter. samples the
 * input clock pin, builds the internal sample clock, delays channel data by
 * the configured latency, and receives the three-wire configuration write.
 * assumes all pins are asynchronous to sys_clk_i and that the serial and
 * input clocks are slow enough to be oversampled (sys_clk_i 20 MHz).
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 40 MHz dual-bus mode samples every rising edge; all other modes every second one.
// - reference power-down high switches off the internal reference.
// - standby high powers the device down; low resumes conversion.
// - conversion runs from the internal sample clock, 40 MHz except 20 MHz in single bus at 40 MHz input.
// - dual bus: latency 8 cycles at 80 MHz option, 4 at 40 MHz.
// - single bus: channel A latency 8 cycles, channel B 9.
// - data captured on falling serial edges, held 5 ns around them.
// - register loads after 16th fall on next rise or cs rise; resets zero.
// - chip select rising before 16 falls leaves the register unchanged.
// - gains apply on second internal clock fall; other bits immediately.
// - clock and bus option bits select one of four output modes.
module dac_ctrl
    import dac_pkg::*;
(
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // converter pins
    input wire logic conv_clk_i,
    input wire logic reference_powerdown_in_i,
    input wire logic standby_in_i,
    // serial configuration port
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic serial_config_data_in_i,
    // raw results from the analog core
    input wire logic [9:0] core_a_i,
    input wire logic [9:0] core_b_i,
    // power controls
    output logic ref_enable_o,
    output logic core_powered_o,
    // gain stages
    output logic [4:0] gain_a_o,
    output logic [4:0] gain_b_o,
    // mode status
    output logic internal_sample_clock_o,
    output logic signed_output_select_o,
    output logic bus_count_option_o,
    output logic clk_option_o,
    output logic cfg_error_o,
    // data outputs
    output logic [9:0] bus_a_o,
    output logic [9:0] bus_b_o,
    output logic bus_b_en_o,
    output logic data_valid_o
);
    logic [1:0] cclk_q, sclk_q, cs_q, sdi_q, standby_in_q, pref_q;
    logic cclk_prev_q, sclk_prev_q, cs_prev_q;
    logic cclk_rise, sclk_fall, sclk_rise, cs_rise;
    logic [15:0] shift_q, cfg_q;
    logic [4:0] scnt_q;
    logic done_tgl_q, done_sync, done_prev_q, done_evt;
    logic [4:0] pend_a_q, pend_b_q;
    logic pend_q;
    logic [1:0] fall_cnt_q;
    logic phase_q;
    logic smp_evt, ick_fall;
    logic [9:0] pipe_a_q [LAT_MAX+1];
    logic [9:0] pipe_b_q [LAT_MAX+1];
    logic [3:0] lat_a, lat_b;
    logic [3:0] fill_q;
    logic err_q, loaded_q, smp80_prev_q;

    // two-flop synchronisers on every pin
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cclk_q <= 2'h0;
            sclk_q <= 2'h3;
            cs_q <= 2'h3;
            sdi_q <= 2'h0;
            standby_in_q <= 2'h0;
            pref_q <= 2'h0;
        end else begin
            cclk_q <= {cclk_q[0], conv_clk_i};
            sclk_q <= {sclk_q[0], sclk_i};
            cs_q <= {cs_q[0], cs_n_i};
            sdi_q <= {sdi_q[0], serial_config_data_in_i};
            standby_in_q <= {standby_in_q[0], standby_in_i};
            pref_q <= {pref_q[0], reference_powerdown_in_i};
        end
    end

    // edge history on synchronised levels
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cclk_prev_q <= 1'b0;
            sclk_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            cclk_prev_q <= cclk_q[1];
            sclk_prev_q <= sclk_q[1];
            cs_prev_q <= cs_q[1];
        end
    end

    assign cclk_rise = cclk_q[1] && !cclk_prev_q;
    assign sclk_fall = !sclk_q[1] && sclk_prev_q;
    assign sclk_rise = sclk_q[1] && !sclk_prev_q;
    assign cs_rise = cs_q[1] && !cs_prev_q;

    // power controls follow the pins
    assign ref_enable_o = !pref_q[1];
    assign core_powered_o = !standby_in_q[1];

    // serial shift register, bits taken on falling edges, msb first
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            shift_q <= CFG_RESET;
            scnt_q <= 5'h0;
        end else if (cs_q[1]) begin
            scnt_q <= 5'h0;
        end else if (sclk_fall && scnt_q != SCNT_LAST) begin
            shift_q <= {shift_q[14:0], sdi_q[1]};
            scnt_q <= scnt_q + 5'h1;
        end
    end

    // load on first rise after 16th fall or on cs rise, whichever is first
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RESET;
            done_tgl_q <= 1'b0;
            err_q <= 1'b0;
            loaded_q <= 1'b0;
        end else if (scnt_q == SCNT_LAST && !loaded_q && (sclk_rise || cs_rise)) begin
            cfg_q <= shift_q;
            done_tgl_q <= !done_tgl_q;
            err_q <= 1'b0;
            loaded_q <= !cs_rise;
        end else if (cs_rise) begin
            err_q <= (scnt_q != SCNT_LAST);
            loaded_q <= 1'b0;
        end
    end

    // loaded_q keeps a later rise or the closing cs rise from loading twice
    assign cfg_error_o = err_q;

    // write-done toggle resynchronised before gain update
    dac_sync #(
        .STAGES(SYNC_STAGES)
    ) u_done_sync (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(done_tgl_q),
        .q_o(done_sync)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            done_prev_q <= 1'b0;
        end else begin
            done_prev_q <= done_sync;
        end
    end
    assign done_evt = done_sync ^ done_prev_q;

    // immediate mode bits
    assign signed_output_select_o = cfg_q[BIT_SIGNED];
    assign clk_option_o = cfg_q[BIT_CLK_OPT];
    assign bus_count_option_o = cfg_q[BIT_BUS_OPT];

    // internal sample clock: every input rise at 40 MHz dual bus, every other rise in all other modes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            phase_q <= 1'b0;
            smp80_prev_q <= 1'b0;
        end else if (cclk_rise) begin
            phase_q <= !phase_q;
            smp80_prev_q <= smp_evt && !(clk_option_o && !bus_count_option_o);
        end
    end
    assign smp_evt = cclk_rise && core_powered_o &&
        ((clk_option_o && !bus_count_option_o) || !phase_q);
    // internal clock falls on each sampling rise (held high in 40 MHz dual mode): ick_fall is the sample event
    assign ick_fall = smp_evt;
    assign internal_sample_clock_o = !phase_q || (clk_option_o && !bus_count_option_o);

    // gain resync: apply on second internal clock fall after write
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pend_q <= 1'b0;
            fall_cnt_q <= 2'h0;
            pend_a_q <= 5'h0;
            pend_b_q <= 5'h0;
            gain_a_o <= 5'h0;
            gain_b_o <= 5'h0;
        end else if (done_evt) begin
            pend_q <= 1'b1;
            fall_cnt_q <= 2'h0;
            pend_a_q <= cfg_q[BIT_GAIN_A_LO +: GAIN_W];
            pend_b_q <= cfg_q[BIT_GAIN_B_LO +: GAIN_W];
        end else if (pend_q && ick_fall) begin
            if (fall_cnt_q + 2'h1 == GAIN_EDGES) begin
                gain_a_o <= pend_a_q;
                gain_b_o <= pend_b_q;
                pend_q <= 1'b0;
            end
            fall_cnt_q <= fall_cnt_q + 2'h1;
        end
    end

    // latency per mode, counted in input clock cycles
    always_comb begin
        if (!bus_count_option_o) begin
            lat_a = clk_option_o ? 4'(LAT_DUAL_40) : 4'(LAT_DUAL_80);
            lat_b = lat_a;
        end else begin
            lat_a = 4'(LAT_SGL_A);
            lat_b = 4'(LAT_SGL_B);
        end
    end

    // input-clock delay line; slot 0 takes the core word on a sample edge
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i <= LAT_MAX; i++) begin
                pipe_a_q[i] <= 10'h0;
                pipe_b_q[i] <= 10'h0;
            end
            fill_q <= 4'h0;
        end else if (cclk_rise) begin
            pipe_a_q[0] <= smp_evt ? core_a_i : pipe_a_q[0];
            pipe_b_q[0] <= smp_evt ? core_b_i : pipe_b_q[0];
            for (int i = 1; i <= LAT_MAX; i++) begin
                pipe_a_q[i] <= pipe_a_q[i-1];
                pipe_b_q[i] <= pipe_b_q[i-1];
            end
            if (fill_q != 4'(LAT_MAX + 1)) begin
                fill_q <= fill_q + 4'h1;
            end
        end
    end

    // output registers with coding select; bus b enable low in single-bus modes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bus_a_o <= 10'h0;
            bus_b_o <= 10'h0;
            data_valid_o <= 1'b0;
        end else begin
            bus_a_o <= pipe_a_q[lat_a] ^ (signed_output_select_o ? SMP_SIGN : 10'h0);
            bus_b_o <= pipe_b_q[lat_b] ^ (signed_output_select_o ? SMP_SIGN : 10'h0);
            data_valid_o <= core_powered_o && fill_q > lat_b;
        end
    end
    assign bus_b_en_o = core_powered_o && !bus_count_option_o;

    // config register only changes at a completed load
    a_cfg_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !(scnt_q == SCNT_LAST && !loaded_q && (sclk_rise || cs_rise)) |=> $stable(cfg_q))
        else $error("config changed without a completed write");
    // a load on a serial clock rise takes the shifted word
    a_cfg_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (scnt_q == SCNT_LAST && !loaded_q && sclk_rise) |=> cfg_q == $past(shift_q))
        else $error("config did not load the shifted word");
    // early cs rise flags an error
    a_short_err: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cs_rise && scnt_q != SCNT_LAST) |=> cfg_error_o)
        else $error("short write not flagged");
    // gains move only on a sample event
    a_gain_edge: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !$stable(gain_a_o) |-> $past(ick_fall && pend_q))
        else $error("gain changed off the sample clock");
    // every toggle change gives a done event 3 to 4 cycles later
    sequence s_tgl_change;
        $changed(done_tgl_q);
    endsequence
    a_done_sync: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_tgl_change |-> ##[3:4] done_evt)
        else $error("write-done not resynchronised in time");
    // 40 MHz dual mode samples every input rise
    a_rate_40: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cclk_rise && clk_option_o && !bus_count_option_o && core_powered_o) |-> smp_evt)
        else $error("missed a 40 MHz sample");
    // 80 MHz modes never sample two rises in a row
    a_rate_80: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (cclk_rise && smp80_prev_q && !(clk_option_o && !bus_count_option_o)) |-> !smp_evt)
        else $error("80 MHz mode sampled consecutive rises");
    // standby withdraws bus b and valid
    a_standby: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        standby_in_q[1] |-> (!bus_b_en_o ##1 !data_valid_o))
        else $error("outputs active in standby");
    // latency table choice
    a_lat_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        bus_count_option_o |-> (lat_a == 4'h8 && lat_b == 4'h9))
        else $error("single-bus latency wrong");
endmodule // dac_ctrl
`default_nettype wire

// file: verilog/dac_pkg.sv
/*
 * package for the dual converter control block: configuration word layout,
 * latency figures, synchroniser depth and timing figures.
 * assumes nothing of its surroundings.
 */
package dac_pkg;
    // serial configuration word
    localparam int unsigned CFG_W = 16;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int unsigned BIT_GAIN_A_LO = 0;
    localparam int unsigned BIT_GAIN_B_LO = 5;
    localparam int unsigned BIT_SIGNED = 10;
    localparam int unsigned BIT_CLK_OPT = 11;
    localparam int unsigned BIT_BUS_OPT = 12;
    localparam int unsigned GAIN_W = 5;
    localparam logic [4:0] SCNT_LAST = 5'h10;
    // sample word
    localparam int unsigned SMP_W = 10;
    localparam logic [9:0] SMP_SIGN = 10'h200;
    // latencies in input clock cycles
    localparam int unsigned LAT_DUAL_80 = 8;
    localparam int unsigned LAT_DUAL_40 = 4;
    localparam int unsigned LAT_SGL_A = 8;
    localparam int unsigned LAT_SGL_B = 9;
    localparam int unsigned LAT_MAX = 9;
    // resync depth for the write-done event
    localparam int unsigned SYNC_STAGES = 3;
    // gain applied on second falling edge of the internal sample clock
    localparam logic [1:0] GAIN_EDGES = 2'h2;
    // clocks
    localparam int unsigned SYS_CLK_NS = 50;
    localparam int unsigned SCLK_MAX_MHZ = 20;
    localparam int unsigned SCLK_MIN_HALF_NS = 25;
    localparam int unsigned SCLK_MIN_HALF_CYC =
        (SCLK_MIN_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
endpackage

// file: verilog/dac_sync.sv
/*
 * dac_sync: multi-stage level synchroniser.
 * assumes the input is asynchronous to clk_i; only the last stage is read.
 */
`timescale 1ns/1ps
`default_nettype none
module dac_sync #(
    parameter int unsigned STAGES = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // level in and out
    input wire logic d_i,
    output logic q_o
);
    logic [STAGES-1:0] sync_q;

    // shift chain; each stage reads only the one before it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[STAGES-2:0], d_i};
        end
    end

    assign q_o = sync_q[STAGES-1];
endmodule // dac_sync
`default_nettype wire
